// ---- rtl/rnp_filter.v ----
// glitch filter for the active-low reset request pin
`timescale 1ns/1ps
module rnp_filter #(
    parameter CNT_W = 4,
    parameter PASS = 5
) (
    input wire clk,
    input wire reset_n,
    input wire pin_in,
    output reg low_out_r
);
    reg [CNT_W-1:0] cnt_r; // consecutive low samples
    // a low run must last PASS samples before it counts; shorter ones vanish
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= {CNT_W{1'b0}};
            low_out_r <= 1'b0;
        end else if (pin_in) begin
            cnt_r <= {CNT_W{1'b0}}; // spike ended early, discard
            low_out_r <= 1'b0;
        end else if (cnt_r == PASS[CNT_W-1:0] - 1'b1) begin
            low_out_r <= 1'b1; // long low recognised
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule // rnp_filter

// ---- rtl/rnp_regs.vh ----
// timing constants and reset values for the reset, nmi and power-down block
// How it works
// - low reset pin with clock running resets
// - filter rejects low pulses under 10 ns
// - low pulses over 100 ns pass unless they end within our own bidir drive
// - bidir mode pulls pin low during sequence
// - indication output low on any reset
// - indication stays low until end of init
// - nmi falling edge raises trap request outside reset
// - power-down with nmi low enters power-down
// - power-down with nmi high is ignored
// - bidir bit locked after init, cleared on reset
// - bidir mode reports long hardware reset
// - bidir mode stretches short hardware reset
`ifndef RNP_REGS_VH
`define RNP_REGS_VH
`define RNP_CLK_MHZ 50
`define RNP_SPIKE_NS 10
`define RNP_PASS_NS 100
// spike cycles round down (rejected), pass cycles round down (accepted)
`define RNP_SPIKE_CYC ((`RNP_SPIKE_NS * `RNP_CLK_MHZ) / 1000)
`define RNP_PASS_CYC ((`RNP_PASS_NS * `RNP_CLK_MHZ) / 1000)
`define RNP_SEQ_CYC 16
`define RNP_SRC_NONE 3'h0
`define RNP_SRC_HW 3'h1
`define RNP_SRC_SW 3'h2
`define RNP_SRC_WDT 3'h4
`endif

// ---- rtl/rnp_reset_nmi_pd.v ----
// reset sequencer, reset indication, nmi edge and power-down gate
`timescale 1ns/1ps
`include "rnp_regs.vh"
module rnp_reset_nmi_pd #(
    parameter SEQ_CYC = `RNP_SEQ_CYC,
    parameter SEQ_W = 8
) (
    input wire clk,
    input wire reset_n,
    input wire reset_request_pin_in,
    output reg reset_request_pin_out_r,
    output reg reset_request_pin_oe_n_r,
    input wire sw_reset_req,
    input wire watchdog_timer_reset_req,
    input wire end_of_init_instruction,
    input wire bidir_reset_enable_wr,
    input wire bidir_reset_enable_wdata,
    input wire power_down_instruction,
    input wire nmi_n_pin,
    output reg bidir_reset_enable_r,
    output reg internal_reset_r,
    output reg reset_indication_output_r,
    output reg [2:0] reset_source_r,
    output reg long_hw_reset_r,
    output reg nmi_trap_r,
    output reg power_down_r
);
    // one-hot sequencer states; a corrupted code falls to the default
    // branch and restarts the sequence rather than running half reset
    localparam ST_RUN = 3'b001;
    localparam ST_HOLD = 3'b010; // filtered request still low
    localparam ST_SEQ = 3'b100; // fixed internal sequence running

    // last count of the sequence; SEQ_W must hold SEQ_CYC - 1, the
    // upper bits of the parameter are cut on purpose
    localparam [SEQ_W-1:0] SEQ_LAST = SEQ_CYC[SEQ_W-1:0] - 1'b1;
    // short low pulses below this may be lost; above it a reset is certain unless the low ends within our own drive
    // the count is in whole clocks, so the accepted length is rounded
    // down; at least one sample is always needed
    localparam PASS = (`RNP_PASS_CYC < 1) ? 1 : `RNP_PASS_CYC;

    wire hw_low; // filtered request, high while pin held low
    reg [2:0] state_r;
    reg [SEQ_W-1:0] seq_cnt_r; // cycles spent in the sequence
    reg nmi_q_r; // previous nmi sample for edge detection
    reg init_done_r; // end of init seen since last reset
    reg echo_r; // we drove the pin in the previous cycle

    // enable seen high: our own open-drain stage pulls the pin now
    wire reset_request_pin_out_oe = ~reset_request_pin_oe_n_r;
    // any state but run keeps the chip in reset
    wire in_reset_nxt = (state_r != ST_RUN);
    // the filter output lags the pin by one edge, so our own drive is
    // still seen for one cycle after release; echo_r covers that cycle,
    // an outside low held past our drive still counts after it
    wire self_mask = reset_request_pin_out_oe | echo_r;
    wire hw_req = hw_low & ~self_mask; // outside reset request

    // true on the last cycle of the internal sequence; used by the
    // sequencer, the pin drive and the bidir clear
    function seq_end(input [2:0] st, input [SEQ_W-1:0] cnt);
        seq_end = (st == ST_SEQ) && (cnt == SEQ_LAST);
    endfunction

    // glitch filter: the pin is taken as synchronous, so a low run is
    // counted in whole clocks; a run shorter than PASS samples never
    // reaches the sequencer
    rnp_filter #(
        .CNT_W(4),
        .PASS(PASS)
    ) u_filter (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(reset_request_pin_in),
        .low_out_r(hw_low)
    );

    // sequencer: any reset source starts the fixed sequence from run; only an outside low restarts it
    // run  - normal operation, sources are watched
    // hold - the filtered pin is still low, the count is held at zero
    // seq  - the fixed internal sequence counts up to SEQ_LAST, then run
    // sw and watchdog requests are only looked at in run
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_SEQ;
            seq_cnt_r <= {SEQ_W{1'b0}};
            reset_source_r <= `RNP_SRC_HW;
            long_hw_reset_r <= 1'b1;
        end else begin
            case (state_r)
                ST_RUN: begin
                    // an outside low wins over the internal sources
                    if (hw_req) begin
                        state_r <= ST_HOLD;
                        reset_source_r <= `RNP_SRC_HW;
                        long_hw_reset_r <= 1'b1;
                    end else if (watchdog_timer_reset_req) begin
                        // watchdog wins when both fire together
                        state_r <= ST_SEQ;
                        seq_cnt_r <= {SEQ_W{1'b0}};
                        reset_source_r <= `RNP_SRC_WDT;
                        long_hw_reset_r <= bidir_reset_enable_r;
                    end else if (sw_reset_req) begin
                        state_r <= ST_SEQ;
                        seq_cnt_r <= {SEQ_W{1'b0}};
                        reset_source_r <= `RNP_SRC_SW;
                        long_hw_reset_r <= bidir_reset_enable_r;
                    end
                end
                ST_HOLD: begin
                    // while the pin is held low we stay in reset
                    // no drive happens here, so the raw filter output
                    // is the outside request
                    seq_cnt_r <= {SEQ_W{1'b0}};
                    if (!hw_low) begin
                        state_r <= ST_SEQ;
                    end
                end
                ST_SEQ: begin
                    // a short hw reset still runs the full count
                    // an outside low restarts the count from hold; our
                    // own drive is masked, else the sequence would loop
                    if (hw_req) begin
                        state_r <= ST_HOLD;
                    end else if (seq_end(state_r, seq_cnt_r)) begin
                        state_r <= ST_RUN;
                    end else begin
                        seq_cnt_r <= seq_cnt_r + 1'b1;
                    end
                end
                default: begin
                    // illegal code: play safe and rerun the sequence
                    state_r <= ST_SEQ;
                    seq_cnt_r <= {SEQ_W{1'b0}};
                end
            endcase
        end
    end

    // echo register: remembers the drive enable one cycle longer so that
    // the filter's late view of our own low is not taken as a request
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            echo_r <= 1'b0;
        end else begin
            echo_r <= reset_request_pin_out_oe;
        end
    end

    // pin drive: open drain, only low, only in bidir mode during the sequence
    // the output value is a constant low; only the enable moves, so an
    // outside open-drain source can share the pin without contention
    // limitation: a push-pull source on the pin would fight our drive
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_request_pin_out_r <= 1'b0;
            reset_request_pin_oe_n_r <= 1'b1;
        end else begin
            reset_request_pin_out_r <= 1'b0;
            // drive stops on the same edge that ends the sequence, so that the
            // pin is back high by the time the chip runs again
            reset_request_pin_oe_n_r <= ~(bidir_reset_enable_r &&
                (state_r == ST_SEQ) && !seq_end(state_r, seq_cnt_r));
        end
    end

    // internal reset, init flag and indication output
    // both outputs follow the same next-state term, so the indication
    // is never high while the internal reset is asserted; end of init
    // only counts once the sequencer is back in run, and a second one
    // before the next reset changes nothing
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            internal_reset_r <= 1'b1;
            init_done_r <= 1'b0;
            reset_indication_output_r <= 1'b0;
        end else begin
            internal_reset_r <= in_reset_nxt;
            if (in_reset_nxt) begin
                init_done_r <= 1'b0;
                reset_indication_output_r <= 1'b0;
            end else if (end_of_init_instruction) begin
                init_done_r <= 1'b1;
                reset_indication_output_r <= 1'b1;
            end
        end
    end

    // bidir enable: cleared by every reset, frozen after end of init
    // writes count only in run and before end of init; a write in the
    // last sequence cycle cannot race the clear, as writes need run
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bidir_reset_enable_r <= 1'b0;
        end else if (seq_end(state_r, seq_cnt_r)) begin
            // cleared as the sequence ends, not as it starts: the pin
            // drive needs the bit for the whole sequence
            bidir_reset_enable_r <= 1'b0;
        end else if (bidir_reset_enable_wr && !init_done_r &&
                     state_r == ST_RUN) begin
            bidir_reset_enable_r <= bidir_reset_enable_wdata;
        end
    end

    // nmi falling edge and power-down gating
    // the edge register idles high like the pin, so no false edge
    // follows reset; the pin level itself gates the power-down request,
    // which is a level test, not an edge, so a late nmi low does not
    // enter power-down on its own
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nmi_q_r <= 1'b1;
            nmi_trap_r <= 1'b0;
            power_down_r <= 1'b0;
        end else begin
            nmi_q_r <= nmi_n_pin;
            nmi_trap_r <= nmi_q_r & ~nmi_n_pin & ~in_reset_nxt;
            if (in_reset_nxt) begin
                power_down_r <= 1'b0; // only reset leaves power-down
            end else if (power_down_instruction && !nmi_n_pin) begin
                power_down_r <= 1'b1;
            end
            // nmi high: instruction has no effect
        end
    end
endmodule // rnp_reset_nmi_pd

// ---- tb/rnp_chk_assertions.sv ----
// checker for the reset, nmi and power-down block
`timescale 1ns/1ps
module rnp_chk (
    input wire clk,
    input wire reset_n,
    input wire reset_request_pin_in,
    input wire reset_request_pin_oe_n_r,
    input wire reset_request_pin_out_r,
    input wire end_of_init_instruction,
    input wire power_down_instruction,
    input wire nmi_n_pin,
    input wire internal_reset_r,
    input wire reset_indication_output_r,
    input wire nmi_trap_r,
    input wire power_down_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    pin_rec_a: assert property ((!reset_request_pin_in &&
        reset_request_pin_oe_n_r)[*5] |-> ##3 internal_reset_r)
        else $error("low run missed");
    ind_low_a: assert property (internal_reset_r |->
        !reset_indication_output_r) else $error("indication high");
    init_rel_a: assert property ($rose(reset_indication_output_r) |->
        $past(end_of_init_instruction) && !$past(internal_reset_r))
        else $error("indication released early");
    nmi_trap_a: assert property ($fell(nmi_n_pin) && !internal_reset_r
        |-> ##[1:2] nmi_trap_r) else $error("nmi trap missing");
    trap_one_a: assert property (nmi_trap_r |=> !nmi_trap_r)
        else $error("nmi trap too long");
    pd_enter_a: assert property (power_down_instruction && !nmi_n_pin
        && !internal_reset_r |=> power_down_r) else $error("pd missed");
    pd_ignore_a: assert property (power_down_instruction && nmi_n_pin
        && !power_down_r |=> !power_down_r) else $error("pd taken");
    drive_seq_a: assert property (!reset_request_pin_oe_n_r |->
        internal_reset_r && !reset_request_pin_out_r) else $error("drive");
endmodule // rnp_chk
bind rnp_reset_nmi_pd rnp_chk i_rnp_chk (.*);

// ---- tb/rnp_ext_src.sv ----
// far-side model: open-drain reset source with pull-up, nmi driver
`timescale 1ns/1ps
module rnp_ext_src (
    input wire clk,
    input wire dev_oe_n,
    output wire pin_level,
    output reg nmi_n_r = 1'b1
);
    reg ext_low_r = 1'b0; // external open-drain stage pulling low
    // wired level: low if either side pulls, pull-up otherwise
    assign pin_level = ~(ext_low_r | ~dev_oe_n);
    // hold the pin low for n clocks; 1 ms is cut short, no boot port here
    task hold_low(input integer n);
        begin
            @(posedge clk) ext_low_r <= 1'b1;
            repeat (n) @(posedge clk);
            ext_low_r <= 1'b0;
        end
    endtask
    // move the nmi line; it stays put between calls
    task nmi_set(input v);
        @(posedge clk) nmi_n_r <= v;
    endtask
endmodule // rnp_ext_src

// ---- tb/tb_top.sv ----
// self-checking bench for the reset, nmi and power-down block
`timescale 1ns/1ps
`include "rnp_regs.vh"
module tb_top;
    reg clk = 0, rst_n = 0, sw = 0, wd = 0, pd = 0, ei = 0, bw = 0, bd = 1;
    wire pin, oe_n, po, nmi, bid, irs, ind, lng, trp, pdn;
    wire [2:0] src; // reset source flags
    integer failures = 0, n_checks = 0, k;
    rnp_reset_nmi_pd i_rnp_reset_nmi_pd (.clk(clk), .reset_n(rst_n),
        .reset_request_pin_in(pin), .reset_request_pin_out_r(po),
        .reset_request_pin_oe_n_r(oe_n), .sw_reset_req(sw),
        .watchdog_timer_reset_req(wd), .end_of_init_instruction(ei),
        .bidir_reset_enable_wr(bw), .bidir_reset_enable_wdata(bd),
        .power_down_instruction(pd), .nmi_n_pin(nmi),
        .bidir_reset_enable_r(bid), .internal_reset_r(irs),
        .reset_indication_output_r(ind), .reset_source_r(src),
        .long_hw_reset_r(lng), .nmi_trap_r(trp), .power_down_r(pdn));
    rnp_ext_src i_rnp_ext_src (.clk(clk), .dev_oe_n(oe_n),
        .pin_level(pin), .nmi_n_r(nmi));
    initial forever #10 clk = ~clk; // 50 MHz
    task chk(input [23:0] nm, input [2:0] e, input [2:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("BAD %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    // n edges, then step past their updates
    task tk(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // one-cycle pulse on {sw, wd, pd, ei, bw}
    task pls(input [4:0] m);
        begin
            @(posedge clk) {sw, wd, pd, ei, bw} <= m;
            @(posedge clk) {sw, wd, pd, ei, bw} <= 5'h00;
            #1;
        end
    endtask
    // bounded wait for release; k counts the edges
    task wrel;
        begin
            k = 0;
            while (irs !== 1'b0 && k < 99) begin
                tk(1);
                k = k + 1;
            end
            if (irs !== 1'b0) begin
                failures = failures + 1;
                final_report;
            end
        end
    endtask
    task eoi;
        begin
            chk("ind", 0, ind);
            pls(5'h02);
            chk("ind", 1, ind);
        end
    endtask
    task t_por;
        begin
            wrel;
            chk("seq", 1, k > 15 && k < 19);
            pls(5'h01);
            chk("bid", 1, bid);
            eoi;
            $display("t_por done");
        end
    endtask
    // short spike ignored, then a short pulse stretched in bidir mode
    task t_spike;
        begin
            i_rnp_ext_src.hold_low(4);
            tk(4);
            chk("spk", 0, irs);
            i_rnp_ext_src.hold_low(7);
            tk(1);
            chk("rec", 1, irs);
            tk(2);
            chk("oe", 0, oe_n);
            chk("ind", 0, ind);
            wrel;
            chk("str", 1, k > 12);
            chk("lng", 1, lng);
            chk("bid", 0, bid);
            eoi;
            $display("t_spike done");
        end
    endtask
    task t_bidir;
        begin
            pls(5'h01);
            chk("bid", 0, bid);
            pls(5'h10);
            tk(1);
            chk("irs", 1, irs);
            chk("oe", 1, oe_n);
            chk("src", `RNP_SRC_SW, src);
            wrel;
            pls(5'h01);
            chk("bid", 1, bid);
            pls(5'h10);
            tk(1);
            chk("oe", 0, oe_n);
            chk("lng", 1, lng);
            wrel;
            chk("bid", 0, bid);
            eoi;
            $display("t_bidir done");
        end
    endtask
    task t_nmi;
        begin
            pls(5'h04);
            chk("pd", 0, pdn);
            i_rnp_ext_src.nmi_set(1'b0);
            tk(1);
            chk("trp", 1, trp);
            tk(1);
            chk("trp", 0, trp);
            tk(1);
            chk("trp", 0, trp);
            pls(5'h04);
            chk("pd", 1, pdn);
            pls(5'h08);
            tk(1);
            chk("src", `RNP_SRC_WDT, src);
            wrel;
            chk("pd", 0, pdn);
            i_rnp_ext_src.nmi_set(1'b1);
            eoi;
            $display("t_nmi done");
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_por;
        t_spike;
        t_bidir;
        t_nmi;
        final_report;
    end
endmodule // tb_top
